// >>> shared/cwp_pkg.sv
// constants and types for the configuration word loader
package cwp_pkg;

  localparam int unsigned MEM_AW      = 10;
  localparam int unsigned MEM_WORDS   = 1024;
  localparam int unsigned WORD_W      = 14;
  localparam int unsigned BUS_AW      = 11;
  localparam int unsigned BUS_DW      = 16;
  localparam int unsigned STACK_DEPTH = 5;
  localparam int unsigned SP_W        = 3;

  // bus map
  localparam logic [BUS_AW-1:0] ADDR_CONFIG = 11'h400;
  localparam logic [BUS_AW-1:0] ADDR_ERASE  = 11'h401;
  localparam logic [BUS_AW-1:0] ADDR_STATUS = 11'h402;
  localparam logic [BUS_AW-1:0] ADDR_PC     = 11'h403;
  localparam logic [15:0]       ERASE_KEY   = 16'h00E5;

  // status bits
  localparam int unsigned ST_BUSY    = 0;
  localparam int unsigned ST_PROTECT = 1;
  localparam int unsigned ST_ERASED  = 2;

  // configuration word fields
  localparam int unsigned CFG_PROTECT = 13;
  localparam int unsigned CFG_XRST    = 12;
  localparam int unsigned CFG_LVR_HI  = 11;
  localparam int unsigned CFG_LVR_LO  = 10;
  localparam int unsigned CFG_WDT_HI  = 9;
  localparam int unsigned CFG_WDT_LO  = 8;
  localparam int unsigned CFG_FRC     = 4;
  localparam logic [WORD_W-1:0] CFG_USED_MASK = 14'h3F10;
  localparam logic [WORD_W-1:0] CFG_RESET     = 14'h0000;
  localparam logic [WORD_W-1:0] ERASED_WORD   = 14'h3FFF;

  // low voltage reset codes
  localparam logic [1:0] LVR_2V0_DETECT = 2'h3;
  localparam logic [1:0] LVR_OFF        = 2'h2;
  localparam logic [1:0] LVR_2V3        = 2'h1;
  localparam logic [1:0] LVR_2V9        = 2'h0;

  // vectors
  localparam logic [MEM_AW-1:0] RESET_VECTOR = 10'h000;
  localparam logic [MEM_AW-1:0] IRQ_VECTOR   = 10'h001;
  localparam logic [MEM_AW-1:0] LAST_ADDR    = 10'h3FF;

  typedef enum logic [1:0]
  {
    RUN_FAST = 2'b00,
    RUN_SLOW = 2'b01,
    RUN_IDLE = 2'b10,
    RUN_STOP = 2'b11
  } cwp_run_type;

  typedef enum logic [0:0]
  {
    ER_IDLE = 1'b0,
    ER_BUSY = 1'b1
  } cwp_erase_type;

  typedef enum logic [1:0]
  {
    RS_MEM   = 2'b00,
    RS_REG   = 2'b01,
    RS_BLOCK = 2'b10
  } cwp_rsel_type;

endpackage

// >>> src/cwp_prog_mem.sv
// program memory with one write port and two registered read ports
`timescale 1ns/1ns
module cwp_prog_mem
  import cwp_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              wr_en,
  input  wire logic [MEM_AW-1:0] wr_addr,
  input  wire logic [WORD_W-1:0] wr_data,
  input  wire logic [MEM_AW-1:0] a_addr,
  output logic      [WORD_W-1:0] a_data,
  input  wire logic [MEM_AW-1:0] b_addr,
  output logic      [WORD_W-1:0] b_data
);

  logic [WORD_W-1:0] mem [MEM_WORDS];

  always_ff @(posedge sys_clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    a_data <= mem[a_addr];
    b_data <= mem[b_addr];
  end

endmodule

// >>> src/cwp_config_loader.sv
// configuration word, program memory access, option decode and vectors
// How it works
// R01: 1K word memory plus separate configuration word
// R02: protect bit set blocks program memory reads
// R03: protect clears only after full user erase
// R04: configuration word always readable by programmer
// R05: only programmer port writes configuration word
// R06: any reset starts program counter at 000h
// R07: reset returns every register to default except the configuration word, which keeps its content, and the memory read data registers
// R08: interrupt pushes current pc_reg address, jumps 001H
// R09: bit 12 makes pin an external reset
// R10: bits 11-10 pick low voltage reset level
// R11: undervoltage detect needs its interrupt enable
// R12: bits 9-8 set watchdog reset policy
// R13: bit 4 picks external or internal RC
// R14: reserved configuration bits never affect decoding
`timescale 1ns/1ns
module cwp_config_loader
  import cwp_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic [BUS_AW-1:0] bus_addr,
  input  wire logic [BUS_DW-1:0] bus_wdata,
  input  wire logic              bus_write,
  input  wire logic              bus_read,
  output logic      [BUS_DW-1:0] bus_rdata,
  input  wire logic              cpu_advance,
  input  wire logic              cpu_jump,
  input  wire logic [MEM_AW-1:0] cpu_jump_addr,
  input  wire logic              cpu_return,
  input  wire logic              irq_take,
  output logic      [MEM_AW-1:0] pc_out,
  output logic      [WORD_W-1:0] fetch_data,
  input  wire logic              undervoltage_irq_enable,
  input  wire cwp_run_type       run_mode,
  input  wire logic              port_a_bit7,
  output logic                   ext_reset_pin_enable,
  output logic                   ext_reset_n,
  output logic                   port_a_bit7_in,
  output logic      [1:0]        low_voltage_reset_select,
  output logic                   low_voltage_reset_enable,
  output logic                   undervoltage_detect,
  output logic                   watchdog_reset_enable,
  output logic                   fast_rc_source_select,
  output logic                   config_ready
);

  function automatic logic [WORD_W-1:0] cfg_clean(input logic [WORD_W-1:0] w);
    cfg_clean = w & CFG_USED_MASK;
  endfunction

  // configuration word and erase sequencer
  logic [WORD_W-1:0] config_word_reg;
  logic [WORD_W-1:0] config_word_next;
  cwp_erase_type     erase_state_reg;
  cwp_erase_type     erase_state_next;
  logic [MEM_AW-1:0] erase_addr_reg;
  logic [MEM_AW-1:0] erase_addr_next;
  logic              erased_reg;
  logic              erased_next;
  logic              mem_wr_en;
  logic [MEM_AW-1:0] mem_wr_addr;
  logic [WORD_W-1:0] mem_wr_data;
  logic              is_mem;
  logic              protect;

  assign is_mem  = (bus_addr[BUS_AW-1] == 1'b0);
  assign protect = config_word_reg[CFG_PROTECT];

  always_comb
  begin
    config_word_next = config_word_reg;
    erase_state_next = erase_state_reg;
    erase_addr_next  = erase_addr_reg;
    erased_next      = erased_reg;
    mem_wr_en        = 1'b0;
    mem_wr_addr      = bus_addr[MEM_AW-1:0];
    mem_wr_data      = bus_wdata[WORD_W-1:0];
    case (erase_state_reg)
      ER_IDLE:
      begin
        if (bus_write && is_mem)
        begin
          mem_wr_en   = 1'b1;
          erased_next = 1'b0;
        end
        if (bus_write && bus_addr == ADDR_CONFIG)  // see R05
        begin
          config_word_next = bus_wdata[WORD_W-1:0];
          if (protect && !erased_reg)
          begin
            config_word_next[CFG_PROTECT] = 1'b1;  // see R03
          end
        end
        if (bus_write && bus_addr == ADDR_ERASE && bus_wdata == ERASE_KEY)
        begin
          erase_state_next = ER_BUSY;
          erase_addr_next  = RESET_VECTOR;
        end
      end
      ER_BUSY:
      begin
        mem_wr_en   = 1'b1;  // see R03
        mem_wr_addr = erase_addr_reg;
        mem_wr_data = ERASED_WORD;
        erase_addr_next = erase_addr_reg + 10'h001;
        if (erase_addr_reg == LAST_ADDR)
        begin
          erase_state_next = ER_IDLE;
          erased_next      = 1'b1;
        end
      end
      default:
      begin
        erase_state_next = ER_IDLE;
      end
    endcase
  end

  // nonvolatile word modelled as a register; reset keeps its content
  always_ff @(posedge sys_clk)
  begin
    config_word_reg <= config_word_next;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      erase_state_reg <= ER_IDLE;  // see R07
      erase_addr_reg  <= RESET_VECTOR;
      erased_reg      <= 1'b0;
    end
    else
    begin
      erase_state_reg <= erase_state_next;
      erase_addr_reg  <= erase_addr_next;
      erased_reg      <= erased_next;
    end
  end

  // bus read path
  cwp_rsel_type      rsel_reg;
  cwp_rsel_type      rsel_next;
  logic [BUS_DW-1:0] rreg_reg;
  logic [BUS_DW-1:0] rreg_next;
  logic [WORD_W-1:0] mem_a_data;
  logic [MEM_AW-1:0] pc_reg;

  always_comb
  begin
    rsel_next = RS_REG;
    rreg_next = '0;
    if (bus_read)
    begin
      if (is_mem)
      begin
        rsel_next = protect ? RS_BLOCK : RS_MEM;  // see R02
      end
      else if (bus_addr == ADDR_CONFIG)
      begin
        rreg_next = {2'h0, config_word_reg};  // see R04
      end
      else if (bus_addr == ADDR_STATUS)
      begin
        rreg_next[ST_BUSY]    = (erase_state_reg == ER_BUSY);
        rreg_next[ST_PROTECT] = protect;
        rreg_next[ST_ERASED]  = erased_reg;
      end
      else if (bus_addr == ADDR_PC)
      begin
        rreg_next = {6'h00, pc_reg};
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rsel_reg <= RS_REG;
      rreg_reg <= '0;
    end
    else
    begin
      rsel_reg <= rsel_next;
      rreg_reg <= rreg_next;
    end
  end

  always_comb
  begin
    case (rsel_reg)
      RS_MEM:   bus_rdata = {2'h0, mem_a_data};
      RS_BLOCK: bus_rdata = '0;  // see R02
      default:  bus_rdata = rreg_reg;
    endcase
  end

  // program memory
  cwp_prog_mem u_mem (  // see R01
    .sys_clk (sys_clk),
    .wr_en   (mem_wr_en),
    .wr_addr (mem_wr_addr),
    .wr_data (mem_wr_data),
    .a_addr  (bus_addr[MEM_AW-1:0]),
    .a_data  (mem_a_data),
    .b_addr  (pc_reg),
    .b_data  (fetch_data)
  );

  // program counter and stack
  logic [MEM_AW-1:0] pc_next;
  logic [MEM_AW-1:0] stack_reg  [STACK_DEPTH];
  logic [MEM_AW-1:0] stack_next [STACK_DEPTH];
  logic [SP_W-1:0]   sp_reg;
  logic [SP_W-1:0]   sp_next;

  always_comb
  begin
    pc_next    = pc_reg;
    stack_next = stack_reg;
    sp_next    = sp_reg;
    if (irq_take)
    begin
      stack_next[0] = pc_reg;  // see R08
      for (int i = 1; i < STACK_DEPTH; i++)
      begin
        stack_next[i] = stack_reg[i-1];
      end
      if (sp_reg != SP_W'(STACK_DEPTH))
      begin
        sp_next = sp_reg + 3'h1;
      end
      pc_next = IRQ_VECTOR;  // see R08
    end
    else if (cpu_return)
    begin
      pc_next = stack_reg[0];
      for (int i = 0; i < STACK_DEPTH - 1; i++)
      begin
        stack_next[i] = stack_reg[i+1];
      end
      if (sp_reg != 3'h0)
      begin
        sp_next = sp_reg - 3'h1;
      end
    end
    else if (cpu_jump)
    begin
      pc_next = cpu_jump_addr;
    end
    else if (cpu_advance)
    begin
      pc_next = pc_reg + 10'h001;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc_reg <= RESET_VECTOR;  // see R06
      sp_reg <= 3'h0;          // see R07
      for (int i = 0; i < STACK_DEPTH; i++)
      begin
        stack_reg[i] <= RESET_VECTOR;
      end
    end
    else
    begin
      pc_reg    <= pc_next;
      sp_reg    <= sp_next;
      stack_reg <= stack_next;
    end
  end

  assign pc_out = pc_reg;

  // options applied once after reset release
  logic [WORD_W-1:0] applied_reg;
  logic [WORD_W-1:0] applied_next;
  logic              ready_reg;
  logic              ready_next;
  logic              pin_s1_reg;
  logic              pin_s2_reg;

  always_comb
  begin
    applied_next = applied_reg;
    ready_next   = 1'b1;
    if (!ready_reg)
    begin
      applied_next = cfg_clean(config_word_reg);  // see R14
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      applied_reg <= CFG_RESET;  // see R07
      ready_reg   <= 1'b0;
      pin_s1_reg  <= 1'b1;
      pin_s2_reg  <= 1'b1;
    end
    else
    begin
      applied_reg <= applied_next;
      ready_reg   <= ready_next;
      pin_s1_reg  <= port_a_bit7;
      pin_s2_reg  <= pin_s1_reg;
    end
  end

  // option decode
  always_comb
  begin
    ext_reset_pin_enable     = applied_reg[CFG_XRST];                       // see R09
    ext_reset_n              = ext_reset_pin_enable ? pin_s2_reg : 1'b1;    // see R09
    port_a_bit7_in           = ext_reset_pin_enable ? 1'b1 : pin_s2_reg;    // see R09
    low_voltage_reset_select = applied_reg[CFG_LVR_HI:CFG_LVR_LO];          // see R10
    low_voltage_reset_enable = (low_voltage_reset_select != LVR_OFF);       // see R10
    undervoltage_detect      = (low_voltage_reset_select == LVR_2V0_DETECT)
                               && undervoltage_irq_enable;                  // see R11
    case (applied_reg[CFG_WDT_HI:CFG_WDT_LO])                               // see R12
      2'h3:    watchdog_reset_enable = 1'b1;
      2'h2:    watchdog_reset_enable = (run_mode == RUN_FAST) || (run_mode == RUN_SLOW);
      default: watchdog_reset_enable = 1'b0;
    endcase
    fast_rc_source_select    = applied_reg[CFG_FRC];                        // see R13
    config_ready             = ready_reg;
  end

endmodule

// >>> testbench/cwp_config_checker.sv
// assertions on the configuration loader ports
`timescale 1ns/1ns
module cwp_config_checker
  import cwp_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire logic              irq_take,
  input wire logic              cpu_return,
  input wire logic [MEM_AW-1:0] pc_out,
  input wire logic              undervoltage_irq_enable,
  input wire logic              ext_reset_pin_enable,
  input wire logic              ext_reset_n,
  input wire logic              port_a_bit7_in,
  input wire logic [1:0]        low_voltage_reset_select,
  input wire logic              low_voltage_reset_enable,
  input wire logic              undervoltage_detect,
  input wire logic              config_ready
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_irq_vector: assert property (irq_take |=> pc_out == IRQ_VECTOR)
    else $error("pc not at interrupt vector");
  a_irq_push_pop: assert property (irq_take ##1 (cpu_return && !irq_take) |=> pc_out == $past(pc_out, 2))
    else $error("return address lost");
  a_reset_pc: assert property ($rose(config_ready) |-> $past(pc_out) == RESET_VECTOR)
    else $error("pc not at reset vector");
  a_lvr_enable: assert property ($stable(low_voltage_reset_select)
    |-> low_voltage_reset_enable == (low_voltage_reset_select != LVR_OFF))
    else $error("low voltage reset enable wrong");
  a_uv_gate: assert property ($stable(undervoltage_irq_enable) && $stable(low_voltage_reset_select)
    |-> undervoltage_detect == (low_voltage_reset_select == LVR_2V0_DETECT && undervoltage_irq_enable))
    else $error("undervoltage detect gating wrong");
  a_pin_no_reset: assert property (!ext_reset_pin_enable && $stable(ext_reset_pin_enable) |-> ext_reset_n)
    else $error("reset from pin while disabled");
  a_pin_gpio_off: assert property (ext_reset_pin_enable && $stable(ext_reset_pin_enable) |-> port_a_bit7_in)
    else $error("pin input seen while reset pin");
  a_opts_frozen: assert property (config_ready |=> $stable(low_voltage_reset_select)
    && $stable(ext_reset_pin_enable))
    else $error("options changed outside reset");
  a_ready_holds: assert property (config_ready |=> config_ready)
    else $error("config ready dropped");
endmodule

bind cwp_config_loader cwp_config_checker u_cwp_config_checker
(
  .sys_clk, .rst_n, .irq_take, .cpu_return, .pc_out, .undervoltage_irq_enable,
  .ext_reset_pin_enable, .ext_reset_n, .port_a_bit7_in, .low_voltage_reset_select,
  .low_voltage_reset_enable, .undervoltage_detect, .config_ready
);

// >>> testbench/cwp_programmer.sv
// programmer tool model driving the register bus
`timescale 1ns/1ns
module cwp_programmer
  import cwp_pkg::*;
(
  input  wire logic              sys_clk,
  output logic      [BUS_AW-1:0] bus_addr,
  output logic      [BUS_DW-1:0] bus_wdata,
  output logic                   bus_write,
  output logic                   bus_read
);
  initial
  begin
    bus_addr  = '0;
    bus_wdata = '0;
    bus_write = 1'b0;
    bus_read  = 1'b0;
  end

  // one strobe cycle, then address and data left at inverted values, strobes low
  task automatic xfer(input logic w, input logic [BUS_AW-1:0] a, input logic [BUS_DW-1:0] d);
    @(posedge sys_clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_write <= w;
    bus_read  <= !w;
    @(posedge sys_clk);
    bus_addr  <= ~a;
    bus_wdata <= ~d;
    bus_write <= 1'b0;
    bus_read  <= 1'b0;
  endtask

  // user code erased before protection is lifted
  task automatic erase();
    xfer(1'b1, ADDR_ERASE, ERASE_KEY);
    repeat (MEM_WORDS + 4) @(posedge sys_clk);
  endtask
endmodule

// >>> testbench/config_word_protect_vectors_tb_top.sv
// self-checking bench for the configuration word loader
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module config_word_protect_vectors_tb_top
  import cwp_pkg::*;
;
  logic              sys_clk, rst_n, bus_write, bus_read, cpu_advance, cpu_jump, cpu_return, irq_take;
  logic              undervoltage_irq_enable, port_a_bit7, ext_reset_pin_enable, ext_reset_n, port_a_bit7_in;
  logic              low_voltage_reset_enable, undervoltage_detect, watchdog_reset_enable;
  logic              fast_rc_source_select, config_ready, rd1;
  logic [BUS_AW-1:0] bus_addr;
  logic [BUS_DW-1:0] bus_wdata, bus_rdata, exp_v;
  logic [MEM_AW-1:0] cpu_jump_addr, pc_out;
  logic [WORD_W-1:0] fetch_data, cfg, d0;
  logic [1:0]        low_voltage_reset_select;
  cwp_run_type       run_mode;
  logic [BUS_DW-1:0] exp_q[$];
  logic [31:0]       seed;
  int                n_fail, n_compared, cyc;

  cwp_config_loader u_cwp_config_loader
  (
    .sys_clk, .rst_n, .bus_addr, .bus_wdata, .bus_write, .bus_read, .bus_rdata, .cpu_advance,
    .cpu_jump, .cpu_jump_addr, .cpu_return, .irq_take, .pc_out, .fetch_data, .undervoltage_irq_enable,
    .run_mode, .port_a_bit7, .ext_reset_pin_enable, .ext_reset_n, .port_a_bit7_in, .low_voltage_reset_select,
    .low_voltage_reset_enable, .undervoltage_detect, .watchdog_reset_enable, .fast_rc_source_select, .config_ready
  );
  cwp_programmer u_cwp_programmer (.sys_clk, .bus_addr, .bus_wdata, .bus_write, .bus_read);

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // read strobe tracked and cycle ceiling
  always @(posedge sys_clk)
  begin
    rd1 <= bus_read;
    cyc <= cyc + 1;
    if (cyc > 6000)
    begin
      n_fail++;
      test_done();
    end
  end

  // read results checked mid-cycle while they stand
  always @(negedge sys_clk)
  begin
    if (rd1)
    begin
      exp_v = exp_q.pop_front();
      `CHK("bus_rdata", exp_v, bus_rdata)
    end
  end

  task automatic rd(input logic [BUS_AW-1:0] a, input logic [BUS_DW-1:0] e);
    exp_q.push_back(e);
    u_cwp_programmer.xfer(1'b0, a, '0);
  endtask

  task automatic wr(input logic [BUS_AW-1:0] a, input logic [BUS_DW-1:0] d);
    u_cwp_programmer.xfer(1'b1, a, d);
  endtask

  task automatic do_reset();
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic chk_opts(input logic [WORD_W-1:0] c);
    @(negedge sys_clk);
    `CHK("ready", 1'b1, config_ready)
    `CHK("pc", RESET_VECTOR, pc_out)
    `CHK("xrst_en", c[CFG_XRST], ext_reset_pin_enable)
    `CHK("lvr_sel", c[11:10], low_voltage_reset_select)
    `CHK("lvr_en", c[11:10] != LVR_OFF, low_voltage_reset_enable)
    `CHK("frc", c[CFG_FRC], fast_rc_source_select)
    seed = xs(seed);
    for (int m = 0; m < 4; m++)
    begin
      @(posedge sys_clk);
      run_mode <= cwp_run_type'(m[1:0]);
      undervoltage_irq_enable <= m[0];
      port_a_bit7 <= seed[m];
      repeat (4) @(negedge sys_clk);
      `CHK("wdt", c[9] & (c[8] | m < 2), watchdog_reset_enable)
      `CHK("uv", c[11:10] == LVR_2V0_DETECT & m[0], undervoltage_detect)
      `CHK("ext_rst", c[CFG_XRST] ? seed[m] : 1'b1, ext_reset_n)
      `CHK("pin_in", c[CFG_XRST] ? 1'b1 : seed[m], port_a_bit7_in)
    end
  endtask

  initial
  begin
    {rst_n, cpu_advance, cpu_jump, cpu_return, irq_take, undervoltage_irq_enable, rd1} = '0;
    {n_fail, n_compared, cyc} = '0;
    port_a_bit7 = 1'b1;
    cpu_jump_addr = '0;
    run_mode = RUN_FAST;
    seed = 32'h0000004A;
    // nonvolatile word given a value while reset holds
    wr(ADDR_CONFIG, 16'h0000);
    do_reset();
    for (int i = 0; i < 4; i++)
    begin
      seed = xs(seed);
      cfg = {1'b0, i[0], i[1:0], i[1:0], seed[7:0]};
      wr(ADDR_CONFIG, {2'h0, cfg});
      rd(ADDR_CONFIG, {2'h0, cfg});
      do_reset();
      chk_opts(cfg);
      $display("test options %0d done", i);
    end
    seed = xs(seed);
    d0 = seed[13:0];
    wr(11'h000, {2'h0, d0});
    wr(11'h3FF, {2'h0, ~d0});
    rd(11'h000, {2'h0, d0});
    rd(11'h3FF, {2'h0, ~d0});
    rd(11'h404, 16'h0000);
    `CHK("fetch", d0, fetch_data)
    $display("test memory done");
    cpu_advance <= 1'b1;
    repeat (3) @(posedge sys_clk);
    cpu_advance <= 1'b0;
    cpu_jump <= 1'b1;
    cpu_jump_addr <= seed[25:16];
    @(posedge sys_clk);
    cpu_jump <= 1'b0;
    irq_take <= 1'b1;
    @(posedge sys_clk);
    irq_take <= 1'b0;
    cpu_return <= 1'b1;
    @(negedge sys_clk);
    `CHK("pc_irq", IRQ_VECTOR, pc_out)
    @(posedge sys_clk);
    cpu_return <= 1'b0;
    @(negedge sys_clk);
    `CHK("pc_ret", seed[25:16], pc_out)
    rd(ADDR_CONFIG, {2'h0, cfg});
    $display("test cpu done");
    cfg = cfg | 14'h2000;
    wr(ADDR_CONFIG, {2'h0, cfg});
    rd(11'h3FF, 16'h0000);
    rd(ADDR_CONFIG, {2'h0, cfg});
    wr(ADDR_CONFIG, {2'h0, cfg & 14'h1FFF});
    rd(ADDR_CONFIG, {2'h0, cfg});
    u_cwp_programmer.erase();
    rd(ADDR_STATUS, 16'h0006);
    wr(ADDR_CONFIG, {2'h0, cfg & 14'h1FFF});
    rd(ADDR_CONFIG, {2'h0, cfg & 14'h1FFF});
    rd(11'h3FF, {2'h0, ERASED_WORD});
    do_reset();
    chk_opts(cfg & 14'h1FFF);
    $display("test protect done");
    test_done();
  end
endmodule
